// file: src/wrwu_pkg.sv
package wrwu_pkg;
   // ***************************************************
   // clocking
   // ***************************************************
   localparam int unsigned CLK_HZ   = 100_000_000;
   localparam int unsigned LF_HZ    = 32000;
   localparam int unsigned LF_DIV   = CLK_HZ / LF_HZ;
   localparam int unsigned LF_W     = 12;
   localparam logic [11:0] LF_DIV_M1 = 12'(LF_DIV - 1);

   // ***************************************************
   // sfr map
   // ***************************************************
   localparam logic [7:0] ADDR_XDH  = 8'hAB;
   localparam logic [7:0] ADDR_XDL  = 8'hAC;
   localparam logic [7:0] ADDR_XCTL = 8'hAD;
   localparam logic [7:0] ADDR_TDIV = 8'hB5;
   localparam logic [7:0] XD_RST    = 8'h00;
   localparam logic [3:0] XCTL_RST  = 4'h0;
   localparam logic [7:0] TDIV_RST  = 8'h03;
   localparam int unsigned CTL_DIR  = 3;
   localparam int unsigned CTL_PEND = 4;

   // ***************************************************
   // indirect addresses and fields
   // ***************************************************
   localparam logic [2:0] IA_WD     = 3'h0;
   localparam logic [2:0] IA_UPPER  = 3'h1;
   localparam logic [2:0] IA_LAT_LO = 3'h2;
   localparam logic [2:0] IA_RTC    = 3'h3;
   localparam logic [2:0] IA_CFG0   = 3'h4;
   localparam logic [2:0] IA_CFG1   = 3'h5;
   localparam int unsigned FT_LSB   = 8;
   localparam int unsigned ST_RTC   = 8;
   localparam int unsigned CFG_W    = 4;
   localparam int unsigned CFG0_PINS = 4;
   localparam logic [15:0] WD_RST   = 16'hFFFF;

   // ***************************************************
   // pin filter and edge codes
   // ***************************************************
   localparam logic [6:0] FILT_N0 = 7'h00;
   localparam logic [6:0] FILT_N1 = 7'h02;
   localparam logic [6:0] FILT_N2 = 7'h08;
   localparam logic [6:0] FILT_N3 = 7'h40;
   localparam int unsigned EDGE_RISE = 0;
   localparam int unsigned EDGE_FALL = 1;

   // transfer sequencer states
   typedef enum logic {WRWU_XS_IDLE, WRWU_XS_PEND} wrwu_xs_t;
endpackage

// file: src/wrwu_pin_filter.sv
`timescale 1ns/100ps
module wrwu_pin_filter (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   // sampling and pin
   input  wire logic       sample_en,
   input  wire logic       pin_in,
   // configuration
   input  wire logic [1:0] filt_code,
   input  wire logic [1:0] edge_code,
   // result
   output logic            wake_pulse
);
   logic [6:0] need;
   logic [6:0] cnt_q;
   logic       filt_q;
   logic       filt_d_q;
   logic       edge_q;

   // stable-sample count per filter code
   always_comb begin
      unique case (filt_code)
         2'h0: need = wrwu_pkg::FILT_N0;
         2'h1: need = wrwu_pkg::FILT_N1;
         2'h2: need = wrwu_pkg::FILT_N2;
         2'h3: need = wrwu_pkg::FILT_N3;
      endcase
   end

   // debounce: new level passes after need stable samples, after one sample when need is 0
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q  <= 7'h00;
         filt_q <= 1'b0;
      end else if (sample_en) begin
         if (pin_in == filt_q) begin
            cnt_q <= 7'h00;
         end else if ({1'b0, cnt_q} + 8'h01 >= {1'b0, need}) begin
            filt_q <= pin_in;
            cnt_q  <= 7'h00;
         end else begin
            cnt_q <= cnt_q + 7'h01;
         end
      end
   end

   // edge detect, two samples behind the filter
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         filt_d_q <= 1'b0;
         edge_q   <= 1'b0;
      end else if (sample_en) begin
         filt_d_q <= filt_q;
         edge_q   <= (filt_q & ~filt_d_q & edge_code[wrwu_pkg::EDGE_RISE]) |
                     (~filt_q & filt_d_q & edge_code[wrwu_pkg::EDGE_FALL]);
      end
   end

   assign wake_pulse = sample_en & edge_q;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   edge_enable_a: assert property (wake_pulse |-> $past(edge_code, 2) != 2'h0 || $past(edge_code) != 2'h0)
      else $error("wake pulse with edge detection off");
endmodule

// file: src/wrwu_top.sv
`timescale 1ns/100ps
module wrwu_top #(
   parameter int unsigned NPINS = 6
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   // sfr bus
   input  wire logic [7:0]       sfr_addr,
   input  wire logic [7:0]       sfr_wdata,
   input  wire logic             sfr_wr,
   input  wire logic             sfr_rd,
   output logic      [7:0]       sfr_rdata,
   // wake pins
   input  wire logic [NPINS-1:0] p0_in,
   // system events
   output logic                  wd_reset,
   output logic                  wakeup_interrupt,
   output logic                  rtc_reload
);
   // ***************************************************
   // declarations
   // ***************************************************
   logic [11:0]      lf_cnt_q;
   logic             lf_en;
   logic [7:0]       tick_divider_q;
   logic [7:0]       tick_cnt_q;
   logic             tick;
   logic [7:0]       xfer_data_high_q;
   logic [7:0]       xfer_data_low_q;
   logic [15:0]      xdata;
   logic [3:0]       xfer_control_q;
   logic [2:0]       ia;
   wrwu_pkg::wrwu_xs_t xs_q;
   logic             pend;
   logic             ctl_wr;
   logic             exec;
   logic             exec_wr;
   logic             exec_rd;
   logic [15:0]      rd_val;
   logic [23:0]      latch_q;
   logic [23:0]      wcnt_q;
   logic             rtc_en_q;
   logic             rtc_wake;
   logic             rtc_reload_q;
   logic             rtc_flag_q;
   logic             stat_clr;
   logic [3:0]       filter_timer_latch_q;
   logic [3:0]       ft_cnt_q;
   logic             fsample;
   logic [3:0]       cfg_q [NPINS];
   logic [NPINS-1:0] pin_wake;
   logic [NPINS-1:0] pin_flag_q;
   logic             wd_active_q;
   logic [15:0]      wd_cnt_q;
   logic             wd_load;
   logic             wd_fire;
   logic             wd_reset_q;
   logic [7:0]       rdata_q;
   logic [11:0]      pend_age_q;
   localparam int unsigned ST_RTC_IDX = wrwu_pkg::ST_RTC;

   // ***************************************************
   // slow clock and tick
   // ***************************************************
   // 32 kHz enable from the reference clock
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lf_cnt_q <= 12'h000;
      end else if (lf_en) begin
         lf_cnt_q <= 12'h000;
      end else begin
         lf_cnt_q <= lf_cnt_q + 12'h001;
      end
   end
   assign lf_en = (lf_cnt_q == wrwu_pkg::LF_DIV_M1);

   // tick every 1 + divider slow periods
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_q <= 8'h00;
      end else if (lf_en) begin
         tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;
      end
   end
   assign tick = lf_en && (tick_cnt_q >= tick_divider_q);

   // ***************************************************
   // sfr registers
   // ***************************************************
   assign ctl_wr = sfr_wr && (sfr_addr == wrwu_pkg::ADDR_XCTL);

   // tick divider register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tick_divider_q <= wrwu_pkg::TDIV_RST;
      end else if (sfr_wr && sfr_addr == wrwu_pkg::ADDR_TDIV) begin
         tick_divider_q <= sfr_wdata;
      end
   end

   // data pair: cpu writes, read transfers load it
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         xfer_data_high_q <= wrwu_pkg::XD_RST;
         xfer_data_low_q  <= wrwu_pkg::XD_RST;
      end else begin
         if (sfr_wr && sfr_addr == wrwu_pkg::ADDR_XDH) begin
            xfer_data_high_q <= sfr_wdata;
         end else if (exec_rd) begin
            xfer_data_high_q <= rd_val[15:8];
         end
         if (sfr_wr && sfr_addr == wrwu_pkg::ADDR_XDL) begin
            xfer_data_low_q <= sfr_wdata;
         end else if (exec_rd) begin
            xfer_data_low_q <= rd_val[7:0];
         end
      end
   end
   assign xdata = {xfer_data_high_q, xfer_data_low_q};

   // control: direction and indirect address
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         xfer_control_q <= wrwu_pkg::XCTL_RST;
      end else if (ctl_wr) begin
         xfer_control_q <= sfr_wdata[wrwu_pkg::CTL_DIR:0];
      end
   end
   assign ia = xfer_control_q[2:0];

   // transfer waits for the next slow edge; a new start wins over completion
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         xs_q <= wrwu_pkg::WRWU_XS_IDLE;
      end else begin
         unique case (xs_q)
            wrwu_pkg::WRWU_XS_IDLE: begin
               if (ctl_wr) begin
                  xs_q <= wrwu_pkg::WRWU_XS_PEND;
               end
            end
            wrwu_pkg::WRWU_XS_PEND: begin
               if (lf_en && !ctl_wr) begin
                  xs_q <= wrwu_pkg::WRWU_XS_IDLE;
               end
            end
         endcase
      end
   end
   assign pend    = (xs_q == wrwu_pkg::WRWU_XS_PEND);
   assign exec    = pend && lf_en;
   assign exec_wr = exec && xfer_control_q[wrwu_pkg::CTL_DIR];
   assign exec_rd = exec && !xfer_control_q[wrwu_pkg::CTL_DIR];

   // indirect read selection
   always_comb begin
      rd_val = 16'h0000;
      unique case (ia)
         wrwu_pkg::IA_WD:     rd_val = wd_cnt_q;
         wrwu_pkg::IA_UPPER:  rd_val = {wcnt_q[23:16], latch_q[23:16]};
         wrwu_pkg::IA_LAT_LO: rd_val = latch_q[15:0];
         wrwu_pkg::IA_RTC:    rd_val = wcnt_q[15:0];
         wrwu_pkg::IA_CFG0,
         wrwu_pkg::IA_CFG1: begin
            rd_val[ST_RTC_IDX] = rtc_flag_q;
            rd_val[NPINS-1:0]  = pin_flag_q;
         end
         default:             rd_val = 16'h0000;
      endcase
   end

   // registered read answer, unmapped reads as zero
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            wrwu_pkg::ADDR_XDH:  rdata_q <= xfer_data_high_q;
            wrwu_pkg::ADDR_XDL:  rdata_q <= xfer_data_low_q;
            wrwu_pkg::ADDR_XCTL: rdata_q <= {3'h0, pend, xfer_control_q};
            wrwu_pkg::ADDR_TDIV: rdata_q <= tick_divider_q;
            default:             rdata_q <= 8'h00;
         endcase
      end
   end
   assign sfr_rdata = rdata_q;

   // ***************************************************
   // wakeup timer
   // ***************************************************
   // reload latch
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         latch_q              <= 24'h000000;
         filter_timer_latch_q <= 4'h0;
      end else if (exec_wr && ia == wrwu_pkg::IA_LAT_LO) begin
         latch_q[15:0] <= xdata;
      end else if (exec_wr && ia == wrwu_pkg::IA_UPPER) begin
         latch_q[23:16]       <= xdata[7:0];
         filter_timer_latch_q <= xdata[wrwu_pkg::FT_LSB +: 4];
      end
   end

   // down-counter with auto reload
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rtc_en_q <= 1'b0;
         wcnt_q   <= 24'h000000;
      end else if (exec_wr && ia == wrwu_pkg::IA_LAT_LO) begin
         rtc_en_q <= 1'b1;
         wcnt_q   <= {latch_q[23:16], xdata};
      end else if (exec_wr && ia == wrwu_pkg::IA_RTC) begin
         rtc_en_q <= 1'b0;
      end else if (tick && rtc_en_q) begin
         wcnt_q <= (wcnt_q == 24'h000000) ? latch_q : wcnt_q - 24'h000001;
      end
   end
   assign rtc_wake = tick && rtc_en_q && (wcnt_q == 24'h000000) && !exec_wr;

   // reload pulse out
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rtc_reload_q <= 1'b0;
      end else begin
         rtc_reload_q <= rtc_wake;
      end
   end
   assign rtc_reload = rtc_reload_q;

   // ***************************************************
   // pin wakeup
   // ***************************************************
   // filter sample rate: every 1 + filter timer slow periods
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ft_cnt_q <= 4'h0;
      end else if (lf_en) begin
         ft_cnt_q <= fsample ? 4'h0 : ft_cnt_q + 4'h1;
      end
   end
   assign fsample = lf_en && (ft_cnt_q >= filter_timer_latch_q);

   // per-pin configuration and filter
   for (genvar i = 0; i < NPINS; i++) begin : g_pin
      localparam logic [2:0] CA = (i < wrwu_pkg::CFG0_PINS) ? wrwu_pkg::IA_CFG0 : wrwu_pkg::IA_CFG1;
      localparam int unsigned CB = (i < wrwu_pkg::CFG0_PINS) ? wrwu_pkg::CFG_W * i
                                   : wrwu_pkg::CFG_W * (i - wrwu_pkg::CFG0_PINS);
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            cfg_q[i] <= 4'h0;
         end else if (exec_wr && ia == CA) begin
            cfg_q[i] <= xdata[CB +: wrwu_pkg::CFG_W];
         end
      end
      wrwu_pin_filter u_filt (
         .ref_clk    (ref_clk),
         .rstn       (rstn),
         .sample_en  (fsample),
         .pin_in     (p0_in[i]),
         .filt_code  (cfg_q[i][1:0]),
         .edge_code  (cfg_q[i][3:2]),
         .wake_pulse (pin_wake[i])
      );
   end

   // sticky wake status, set wins over status-read clear
   assign stat_clr = exec_rd && (ia == wrwu_pkg::IA_CFG0 || ia == wrwu_pkg::IA_CFG1);
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rtc_flag_q <= 1'b0;
         pin_flag_q <= '0;
      end else begin
         rtc_flag_q <= rtc_wake | (rtc_flag_q & ~stat_clr);
         pin_flag_q <= pin_wake | (pin_flag_q & {NPINS{~stat_clr}});
      end
   end
   assign wakeup_interrupt = rtc_flag_q | (|pin_flag_q);

   // ***************************************************
   // watchdog
   // ***************************************************
   assign wd_load = exec_wr && (ia == wrwu_pkg::IA_WD);
   assign wd_fire = tick && wd_active_q && (wd_cnt_q <= 16'h0001) && !wd_load;

   // arm on first control write, never disarm
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wd_active_q <= 1'b0;
      end else if (ctl_wr) begin
         wd_active_q <= 1'b1;
      end
   end

   // count and load
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wd_cnt_q <= wrwu_pkg::WD_RST;
      end else if (wd_load) begin
         wd_cnt_q <= xdata;
      end else if (tick && wd_active_q && wd_cnt_q != 16'h0000) begin
         wd_cnt_q <= wd_cnt_q - 16'h0001;
      end
   end

   // one-cycle reset request
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wd_reset_q <= 1'b0;
      end else begin
         wd_reset_q <= wd_fire;
      end
   end
   assign wd_reset = wd_reset_q;

   // ***************************************************
   // checks
   // ***************************************************
   // age of an outstanding transfer
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pend_age_q <= 12'h000;
      end else if (!pend || ctl_wr) begin
         pend_age_q <= 12'h000;
      end else begin
         pend_age_q <= pend_age_q + 12'h001;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_exec_wr(logic [2:0] a);
      exec_wr && ia == a;
   endsequence

   sequence s_rtc_zero;
      tick && rtc_en_q && wcnt_q == 24'h000000 && !exec_wr;
   endsequence

   tick_period_a: assert property (tick |-> lf_en && tick_cnt_q >= tick_divider_q ##1 tick_cnt_q == 8'h00)
      else $error("tick counter not restarted");
   rtc_reload_a: assert property (s_rtc_zero |=> wcnt_q == $past(latch_q) && rtc_reload)
      else $error("wake counter did not reload");
   rtc_enable_a: assert property (s_exec_wr(wrwu_pkg::IA_LAT_LO) |=> rtc_en_q && wcnt_q == latch_q)
      else $error("latch write did not enable and reload");
   rtc_disable_a: assert property (s_exec_wr(wrwu_pkg::IA_RTC) |=> !rtc_en_q ##1 $stable(wcnt_q))
      else $error("timer still running after disable");
   wake_flag_a: assert property (s_rtc_zero |=> rtc_flag_q && wakeup_interrupt)
      else $error("timer wake not flagged");
   wd_load_a: assert property (s_exec_wr(wrwu_pkg::IA_WD) |=> wd_cnt_q == $past(xdata))
      else $error("watchdog not loaded");
   wd_fire_a: assert property (tick && wd_active_q && wd_cnt_q == 16'h0001 && !wd_load
                               |=> wd_cnt_q == 16'h0000 && wd_reset)
      else $error("watchdog expiry missed");
   wd_sticky_a: assert property (wd_active_q |=> wd_active_q)
      else $error("watchdog disarmed");
   pend_bound_a: assert property (pend_age_q <= wrwu_pkg::LF_DIV_M1)
      else $error("transfer pending too long");
   pend_set_a: assert property (ctl_wr |=> pend && pend_age_q == 12'h000)
      else $error("control write not pending");
endmodule

// file: verif/wrwu_pin_src.sv
`timescale 1ns/100ps
// ***************************************************
// port pin source, levels launched on the clock edge
// ***************************************************
module wrwu_pin_src (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   // commanded levels and pins
   input  wire logic [5:0] pin_cmd,
   output logic      [5:0] pin_q
);
   // pins follow the command one edge later, low in reset
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pin_q <= 6'h00;
      end else begin
         pin_q <= pin_cmd;
      end
   end
endmodule

// file: verif/wrwu_top_tb.sv
`timescale 1ns/100ps
module wrwu_top_tb;
   // ***************************************************
   // signals
   // ***************************************************
   logic        ref_clk;
   logic        rstn;
   logic [7:0]  sfr_addr;
   logic [7:0]  sfr_wdata;
   logic        sfr_wr;
   logic        sfr_rd;
   logic [7:0]  sfr_rdata;
   logic [5:0]  pin_cmd;
   logic [5:0]  p0_in;
   logic        wd_reset;
   logic        wakeup_interrupt;
   logic        rtc_reload;
   logic [7:0]  rd_v;
   logic [15:0] w16;
   int          n;
   int          snap;
   int          reload_cnt = 0;
   int          miscompares = 0;
   int          check_count = 0;

   wrwu_top #(.NPINS(6)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .p0_in(p0_in), .wd_reset(wd_reset),
      .wakeup_interrupt(wakeup_interrupt), .rtc_reload(rtc_reload));
   wrwu_pin_src i_pins (.ref_clk(ref_clk), .rstn(rstn), .pin_cmd(pin_cmd), .pin_q(p0_in));

   // clock and reload pulse counter
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (rtc_reload === 1'b1) reload_cnt <= reload_cnt + 1;

   // ***************************************************
   // tasks
   // ***************************************************
   task automatic cmp(input logic [15:0] g, input logic [15:0] e, input string m);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk) #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge ref_clk) #1;
      sfr_wr = 1'b0;
   endtask
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk) #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge ref_clk) #1;
      sfr_rd = 1'b0;
      @(posedge ref_clk) #1;
      d = sfr_rdata;
   endtask
   // poll pending under a bound, the slow side takes up to 3125 cycles
   task automatic wait_idle();
      logic [7:0] c;
      for (int i = 0; i < 40; i++) begin
         sfr_read(wrwu_pkg::ADDR_XCTL, c);
         if (c[4] === 1'b0) return;
         repeat (100) @(posedge ref_clk);
      end
      cmp(16'(c[4]), 16'h0, "pending stuck");
   endtask
   task automatic xfer_wr(input logic [2:0] ia, input logic [15:0] d);
      sfr_write(wrwu_pkg::ADDR_XDH, d[15:8]);
      sfr_write(wrwu_pkg::ADDR_XDL, d[7:0]);
      sfr_write(wrwu_pkg::ADDR_XCTL, {5'h01, ia});
      wait_idle();
   endtask
   task automatic xfer_rd(input logic [2:0] ia, output logic [15:0] d);
      sfr_write(wrwu_pkg::ADDR_XCTL, {5'h00, ia});
      wait_idle();
      sfr_read(wrwu_pkg::ADDR_XDH, d[15:8]);
      sfr_read(wrwu_pkg::ADDR_XDL, d[7:0]);
   endtask
   // cycles until a reload pulse, a reset pulse or the sticky wake interrupt is seen, -1 if none within lim
   task automatic wait_sig(input int which, input int lim, output int cyc);
      cyc = -1;
      for (int i = 1; i <= lim; i++) begin
         @(posedge ref_clk) #1;
         if ((which == 0 && rtc_reload === 1'b1) || (which == 1 && wd_reset === 1'b1) ||
             (which == 2 && wakeup_interrupt === 1'b1)) begin
            cyc = i;
            return;
         end
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ***************************************************
   // tests
   // ***************************************************
   initial begin
      rstn = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      pin_cmd = 6'h00;
      repeat (5) @(posedge ref_clk);
      #1 rstn = 1'b1;
      // reset values, unmapped place, divider access
      sfr_read(wrwu_pkg::ADDR_XDH, rd_v);
      cmp(16'(rd_v), 16'h0000, "data high reset");
      sfr_read(wrwu_pkg::ADDR_XDL, rd_v);
      cmp(16'(rd_v), 16'h0000, "data low reset");
      sfr_read(wrwu_pkg::ADDR_XCTL, rd_v);
      cmp(16'(rd_v), 16'h0000, "control reset");
      sfr_read(wrwu_pkg::ADDR_TDIV, rd_v);
      cmp(16'(rd_v), 16'h0003, "divider reset");
      sfr_write(8'hAE, 8'h5A);
      sfr_read(8'hAE, rd_v);
      cmp(16'(rd_v), 16'h0000, "unmapped read");
      sfr_write(wrwu_pkg::ADDR_TDIV, 8'h00);
      sfr_read(wrwu_pkg::ADDR_TDIV, rd_v);
      cmp(16'(rd_v), 16'h0000, "divider write");
      $display("test registers done");
      // watchdog load and readback, one tick per slow period now
      xfer_wr(wrwu_pkg::IA_WD, 16'h1234);
      sfr_read(wrwu_pkg::ADDR_XCTL, rd_v);
      cmp(16'(rd_v), 16'h0008, "control fields");
      xfer_rd(wrwu_pkg::IA_WD, w16);
      cmp(16'(w16 <= 16'h1234 && w16 >= 16'h1231), 16'h1, "watchdog count");
      $display("test watchdog load done");
      // wake timer: N = 2, first wake and period
      xfer_wr(wrwu_pkg::IA_UPPER, 16'h0000);
      xfer_wr(wrwu_pkg::IA_LAT_LO, 16'h0002);
      wait_sig(0, 13000, n);
      cmp(16'(n >= 9175 && n <= 12505), 16'h1, "first wake");
      wait_sig(0, 13000, n);
      cmp(16'(n), 16'(9375), "wake period");
      cmp(16'(wakeup_interrupt), 16'h1, "wake flag");
      xfer_wr(wrwu_pkg::IA_RTC, 16'hFFFF);
      snap = reload_cnt;
      xfer_rd(wrwu_pkg::IA_CFG0, w16);
      cmp(w16, 16'h0100, "timer status");
      xfer_rd(wrwu_pkg::IA_LAT_LO, w16);
      cmp(w16, 16'h0002, "latch low");
      $display("test wake timer done");
      // pins: pin0 rising, pin1 falling, both go high
      xfer_wr(wrwu_pkg::IA_CFG0, 16'h0084);
      cmp(16'(wakeup_interrupt), 16'h0, "flags clear");
      pin_cmd = 6'h03;
      wait_sig(2, 20000, n);
      cmp(16'(n > 0), 16'h1, "pin wake");
      xfer_rd(wrwu_pkg::IA_CFG1, w16);
      cmp(w16, 16'h0001, "pin status");
      cmp(16'(reload_cnt - snap), 16'h0000, "timer stays off");
      pin_cmd = 6'h00;
      wait_sig(2, 20000, n);
      cmp(16'(n > 0), 16'h1, "pin fall wake");
      xfer_rd(wrwu_pkg::IA_CFG1, w16);
      cmp(w16, 16'h0002, "pin fall status");
      $display("test pins done");
      // watchdog expiry after two ticks
      xfer_wr(wrwu_pkg::IA_WD, 16'h0002);
      wait_sig(1, 7000, n);
      cmp(16'(n >= 6000 && n <= 6260), 16'h1, "watchdog reset");
      $display("test watchdog expiry done");
      stop_test();
   end

   // hang guard, the tests need about 80000 cycles
   initial begin
      repeat (95000) @(posedge ref_clk);
      miscompares++;
      $display("[FAIL] %0t run did not finish", $time);
      stop_test();
   end
endmodule
